// *** design/ebr_embedded_block_ram.sv ***
`timescale 1ns/1ps
`default_nettype none

module ebr_embedded_block_ram #(
   parameter ebr_pkg::ebr_mode_t MODE = ebr_pkg::EBR_TRUE_DUAL,
   parameter int WIDTH_A = 9,
   parameter int WIDTH_B = 9,
   parameter bit OUT_REG_A = 1'b0,
   parameter bit OUT_REG_B = 1'b0,
   parameter logic [ebr_pkg::MEM_BITS-1:0] INIT_BITS = '0
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // port a: write in every mode, read in single and true dual
   input wire ebr_pkg::ebr_req_t req_a,
   output logic [ebr_pkg::DATA_W-1:0] rdata_a,
   // port b: read/write in true dual, read in pseudo dual, pop in fifo
   input wire ebr_pkg::ebr_req_t req_b,
   output logic [ebr_pkg::DATA_W-1:0] rdata_b,
   // status
   output logic fifo_full,
   output logic fifo_empty,
   output logic config_legal
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic int depth_of(input int w);
      if (w % ebr_pkg::PARITY_GROUP == 0) begin
         return ebr_pkg::MEM_BITS / w;
      end
      return ebr_pkg::NARROW_BITS / w;
   endfunction

   function automatic bit width_ok(input int w, input bit wide_allowed);
      return (w == 1) || (w == 2) || (w == 4) || (w == ebr_pkg::PARITY_GROUP) ||
             (wide_allowed && (w == ebr_pkg::WIDE_WORD));
   endfunction

   function automatic bit in_range(input logic [ebr_pkg::ADDR_W-1:0] a, input int w);
      return int'(a) < depth_of(w);
   endfunction

   // word k of width w starts at bit k*w, whatever the other port uses
   function automatic logic [ebr_pkg::PTR_W-1:0] bit_base(input logic [ebr_pkg::ADDR_W-1:0] a,
                                                         input int w);
      return ebr_pkg::PTR_W'(int'(a) * w);
   endfunction

   function automatic logic [ebr_pkg::DATA_W-1:0] read_word(input logic [ebr_pkg::MEM_BITS-1:0] m,
                                                           input logic [ebr_pkg::PTR_W-1:0] base,
                                                           input int w);
      logic [ebr_pkg::DATA_W-1:0] r;
      r = '0;
      for (int i = 0; i < ebr_pkg::DATA_W; i++) begin
         if (i < w && int'(base) + i < ebr_pkg::MEM_BITS) begin
            r[i] = m[int'(base) + i];
         end
      end
      return r;
   endfunction

   function automatic logic [ebr_pkg::PTR_W-1:0] next_ptr(input logic [ebr_pkg::PTR_W-1:0] p,
                                                         input int w, input int cap);
      if (int'(p) + w >= cap) begin
         return ebr_pkg::PTR_W'(int'(p) + w - cap);
      end
      return ebr_pkg::PTR_W'(int'(p) + w);
   endfunction

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   localparam bit IS_FIFO = (MODE == ebr_pkg::EBR_FIFO);
   localparam bit WIDE_OK = (MODE == ebr_pkg::EBR_PSEUDO_DUAL) || IS_FIFO;
   localparam bit A_READS = (MODE == ebr_pkg::EBR_SINGLE) || (MODE == ebr_pkg::EBR_TRUE_DUAL);
   localparam bit B_WRITES = (MODE == ebr_pkg::EBR_TRUE_DUAL);
   localparam bit B_USED = (MODE != ebr_pkg::EBR_SINGLE);
   // widths are free per port; single port makes port b's width irrelevant
   localparam bit LEGAL = width_ok(WIDTH_A, WIDE_OK) &&
                          (!B_USED || width_ok(WIDTH_B, WIDE_OK));
   // fifo ring is a whole number of words on both ports unless only one port's width is a multiple of 9
   localparam int FIFO_CAP = ((WIDTH_A % ebr_pkg::PARITY_GROUP == 0) &&
                              (WIDTH_B % ebr_pkg::PARITY_GROUP == 0)) ?
                             ebr_pkg::MEM_BITS : ebr_pkg::NARROW_BITS;

   // ------------------------------------------------------------
   // input registers
   // ------------------------------------------------------------
   ebr_pkg::ebr_req_t req_a_q;
   ebr_pkg::ebr_req_t req_b_q;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         req_a_q <= ebr_pkg::RESET_REQ;
         req_b_q <= ebr_pkg::RESET_REQ;
      end else begin
         req_a_q <= req_a;
         req_b_q <= B_USED ? req_b : ebr_pkg::RESET_REQ;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         config_legal <= 1'b0;
      end else begin
         config_legal <= LEGAL;
      end
   end

   // ------------------------------------------------------------
   // fifo pointers and flags
   // ------------------------------------------------------------
   logic [ebr_pkg::PTR_W-1:0] wr_ptr;
   logic [ebr_pkg::PTR_W-1:0] rd_ptr;
   logic [ebr_pkg::PTR_W-1:0] fill;
   logic [ebr_pkg::PTR_W-1:0] next_fill;
   logic push;
   logic pop;

   // requests against a full or empty ring are dropped without trace
   assign push = IS_FIFO && req_a_q.en && req_a_q.we && !fifo_full;
   assign pop = IS_FIFO && req_b_q.en && !fifo_empty;

   always_comb begin
      next_fill = fill;
      if (push) begin
         next_fill = ebr_pkg::PTR_W'(int'(next_fill) + WIDTH_A);
      end
      if (pop) begin
         next_fill = ebr_pkg::PTR_W'(int'(next_fill) - WIDTH_B);
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wr_ptr <= ebr_pkg::RESET_PTR;
         rd_ptr <= ebr_pkg::RESET_PTR;
         fill <= ebr_pkg::RESET_PTR;
         fifo_full <= 1'b0;
         fifo_empty <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr <= next_ptr(wr_ptr, WIDTH_A, FIFO_CAP);
         end
         if (pop) begin
            rd_ptr <= next_ptr(rd_ptr, WIDTH_B, FIFO_CAP);
         end
         fill <= next_fill;
         fifo_full <= int'(next_fill) + WIDTH_A > FIFO_CAP;
         fifo_empty <= int'(next_fill) < WIDTH_B;
      end
   end

   // ------------------------------------------------------------
   // storage array
   // ------------------------------------------------------------
   logic [ebr_pkg::MEM_BITS-1:0] mem;
   logic [ebr_pkg::PTR_W-1:0] base_a;
   logic [ebr_pkg::PTR_W-1:0] base_b;
   logic wr_a;
   logic wr_b;

   assign base_a = IS_FIFO ? wr_ptr : bit_base(req_a_q.addr, WIDTH_A);
   assign base_b = bit_base(req_b_q.addr, WIDTH_B);
   // with we held low nothing below fires and the preload stays readable
   assign wr_a = IS_FIFO ? push : (req_a_q.en && req_a_q.we && in_range(req_a_q.addr, WIDTH_A));
   assign wr_b = B_WRITES && req_b_q.en && req_b_q.we && in_range(req_b_q.addr, WIDTH_B);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mem <= INIT_BITS;
      end else begin
         // port a is written last, so it wins a same-bit collision
         if (wr_b) begin
            for (int i = 0; i < WIDTH_B; i++) begin
               mem[int'(base_b) + i] <= req_b_q.data[i];
            end
         end
         if (wr_a) begin
            for (int i = 0; i < WIDTH_A; i++) begin
               mem[int'(base_a) + i] <= req_a_q.data[i];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // array read registers
   // ------------------------------------------------------------
   logic [ebr_pkg::DATA_W-1:0] raw_a;
   logic [ebr_pkg::DATA_W-1:0] raw_b;

   // reads see the array before this edge's write: read-before-write
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         raw_a <= ebr_pkg::RESET_DATA;
         raw_b <= ebr_pkg::RESET_DATA;
      end else begin
         if (A_READS && req_a_q.en && !req_a_q.we) begin
            raw_a <= in_range(req_a_q.addr, WIDTH_A) ? read_word(mem, base_a, WIDTH_A) :
                     ebr_pkg::RESET_DATA;
         end
         if (IS_FIFO) begin
            if (pop) begin
               raw_b <= read_word(mem, rd_ptr, WIDTH_B);
            end
         end else if (B_USED && req_b_q.en && !req_b_q.we) begin
            raw_b <= in_range(req_b_q.addr, WIDTH_B) ? read_word(mem, base_b, WIDTH_B) :
                     ebr_pkg::RESET_DATA;
         end
      end
   end

   // ------------------------------------------------------------
   // output stages
   // ------------------------------------------------------------
   // wider or deeper memories are built outside from several instances:
   // en acts as the block select, and the fabric muxes rdata
   ebr_out_stage #(.WIDTH(ebr_pkg::DATA_W), .REGISTERED(OUT_REG_A)) u_out_a (
      .mclk(mclk),
      .reset(reset),
      .d_in(raw_a),
      .q(rdata_a)
   );

   ebr_out_stage #(.WIDTH(ebr_pkg::DATA_W), .REGISTERED(OUT_REG_B)) u_out_b (
      .mclk(mclk),
      .reset(reset),
      .d_in(raw_b),
      .q(rdata_b)
   );

endmodule

`default_nettype wire

// *** design/ebr_out_stage.sv ***
package ebr_pkg;
   // ------------------------------------------------------------
   // array geometry
   // ------------------------------------------------------------
   localparam int MEM_BITS = 9216;
   localparam int NARROW_BITS = 8192;
   localparam int ADDR_W = 13;
   localparam int PTR_W = 14;
   localparam int DATA_W = 18;
   localparam int WIDE_WORD = 18;
   localparam int PARITY_GROUP = 9;
   localparam logic [DATA_W-1:0] RESET_DATA = 18'h00000;
   localparam logic [PTR_W-1:0] RESET_PTR = 14'h0000;

   // ------------------------------------------------------------
   // modes and carriers
   // ------------------------------------------------------------
   typedef enum {
      EBR_SINGLE,
      EBR_TRUE_DUAL,
      EBR_PSEUDO_DUAL,
      EBR_FIFO
   } ebr_mode_t;

   typedef struct packed {
      logic en;
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } ebr_req_t;

   localparam ebr_req_t RESET_REQ = '0;
endpackage

`timescale 1ns/1ps
`default_nettype none

module ebr_out_stage #(
   parameter int WIDTH = 18,
   parameter bit REGISTERED = 1'b0
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // data
   input wire logic [WIDTH-1:0] d_in,
   output var logic [WIDTH-1:0] q
);

   // ------------------------------------------------------------
   // optional output register
   // ------------------------------------------------------------
   generate
      if (REGISTERED) begin : g_reg
         always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
               q <= '0;
            end else begin
               q <= d_in;
            end
         end
      end else begin : g_bypass
         // bypass trades one cycle of latency for a longer clock-to-out path
         always_comb begin
            q = d_in;
         end
      end
   endgenerate

endmodule

`default_nettype wire

// *** testbench/ebr_fabric_user.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebr_fabric_user (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // bench commands
   input wire logic go,
   input wire logic we,
   input wire logic rom_only,
   input wire logic [ebr_pkg::ADDR_W-1:0] addr,
   input wire logic [ebr_pkg::DATA_W-1:0] data,
   // memory port
   output var ebr_pkg::ebr_req_t req
);
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         req <= ebr_pkg::RESET_REQ;
      end else if (go) begin
         req.en <= 1'b1;
         req.we <= we && !rom_only;
         req.addr <= addr;
         req.data <= data;
      end else begin
         // idle lines scramble so nothing leans on a stale request
         req.en <= 1'b0;
         req.we <= ~req.we;
         req.addr <= ~req.addr;
         req.data <= ~req.data;
      end
   end
endmodule
`default_nettype wire

// *** testbench/ebr_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebr_checker #(
   parameter ebr_pkg::ebr_mode_t MODE = ebr_pkg::EBR_TRUE_DUAL,
   parameter int WIDTH_A = 9,
   parameter int WIDTH_B = 9,
   parameter bit OUT_REG_A = 1'b0,
   parameter bit OUT_REG_B = 1'b0
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // ports
   input wire ebr_pkg::ebr_req_t req_a,
   input wire ebr_pkg::ebr_req_t req_b,
   input wire logic [ebr_pkg::DATA_W-1:0] rdata_a,
   input wire logic [ebr_pkg::DATA_W-1:0] rdata_b,
   // status
   input wire logic fifo_full,
   input wire logic fifo_empty,
   input wire logic config_legal
);
   localparam bit FIFO = (MODE == ebr_pkg::EBR_FIFO);
   wire logic rd_a = req_a.en && !req_a.we;
   wire logic rd_b = req_b.en && (!req_b.we || MODE != ebr_pkg::EBR_TRUE_DUAL);
   wire logic push = req_a.en && req_a.we;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   a_upper_a_zero: assert property ((rdata_a >> WIDTH_A) == '0) else $error("rdata_a upper bits set");
   a_upper_b_zero: assert property ((rdata_b >> WIDTH_B) == '0) else $error("rdata_b upper bits set");
   a_rdata_a_cause: assert property (!$stable(rdata_a) |-> $past(rd_a, 2 + OUT_REG_A))
      else $error("rdata_a moved off its latency");
   a_rdata_b_cause: assert property (!$stable(rdata_b) |-> $past(rd_b, 2 + OUT_REG_B))
      else $error("rdata_b moved off its latency");
   a_empty_by_pop: assert property ($rose(fifo_empty) |-> $past(rd_b, 2)) else $error("empty without pop");
   a_fill_by_push: assert property ($fell(fifo_empty) |-> $past(push, 2)) else $error("data without push");
   a_full_by_push: assert property ($rose(fifo_full) |-> $past(push, 2)) else $error("full without push");
   a_flags_quiet: assert property (FIFO || (fifo_empty && !fifo_full)) else $error("flags outside fifo");
   a_legal_steady: assert property (!$past(reset, 2) |-> config_legal && $stable(config_legal))
      else $error("config_legal wrong");
endmodule
bind ebr_embedded_block_ram ebr_checker #(.MODE(MODE), .WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B),
   .OUT_REG_A(OUT_REG_A), .OUT_REG_B(OUT_REG_B)) ebr_checker_i (.mclk(mclk), .reset(reset),
   .req_a(req_a), .req_b(req_b), .rdata_a(rdata_a), .rdata_b(rdata_b), .fifo_full(fifo_full),
   .fifo_empty(fifo_empty), .config_legal(config_legal));
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [ebr_pkg::MEM_BITS-1:0] INIT = {{(ebr_pkg::MEM_BITS-18){1'b0}}, 18'h2b4c9};
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] go = 8'h00;
   logic [7:0] we = 8'h00;
   logic [7:0] rom = 8'h00;
   logic [12:0] addr [8] = '{default: 13'h0000};
   logic [17:0] data [8] = '{default: 18'h00000};
   ebr_pkg::ebr_req_t req [8];
   logic [17:0] rd [8];
   logic [3:0] full, empty, legal;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #2.5 mclk = ~mclk;
   for (genvar i = 0; i < 8; i++) begin : g_user
      ebr_fabric_user ebr_fabric_user_i (.mclk(mclk), .reset(reset), .go(go[i]), .we(we[i]),
         .rom_only(rom[i]), .addr(addr[i]), .data(data[i]), .req(req[i]));
   end
   ebr_embedded_block_ram #(.WIDTH_B(1), .OUT_REG_B(1'b1), .INIT_BITS(INIT)) ebr_embedded_block_ram_i (
      .mclk(mclk), .reset(reset), .req_a(req[0]), .rdata_a(rd[0]), .req_b(req[1]), .rdata_b(rd[1]),
      .fifo_full(full[0]), .fifo_empty(empty[0]), .config_legal(legal[0]));
   if (1) begin : g_fifo
      ebr_embedded_block_ram #(.MODE(ebr_pkg::EBR_FIFO), .WIDTH_A(18)) ebr_embedded_block_ram_i (
         .mclk(mclk), .reset(reset), .req_a(req[2]), .rdata_a(rd[2]), .req_b(req[3]), .rdata_b(rd[3]),
         .fifo_full(full[1]), .fifo_empty(empty[1]), .config_legal(legal[1]));
   end
   if (1) begin : g_single
      ebr_embedded_block_ram #(.MODE(ebr_pkg::EBR_SINGLE), .WIDTH_A(4), .OUT_REG_A(1'b1)) ebr_embedded_block_ram_i (
         .mclk(mclk), .reset(reset), .req_a(req[4]), .rdata_a(rd[4]), .req_b(req[5]), .rdata_b(rd[5]),
         .fifo_full(full[2]), .fifo_empty(empty[2]), .config_legal(legal[2]));
   end
   if (1) begin : g_pseudo
      ebr_embedded_block_ram #(.MODE(ebr_pkg::EBR_PSEUDO_DUAL), .WIDTH_B(18)) ebr_embedded_block_ram_i (
         .mclk(mclk), .reset(reset), .req_a(req[6]), .rdata_a(rd[6]), .req_b(req[7]), .rdata_b(rd[7]),
         .fifo_full(full[3]), .fifo_empty(empty[3]), .config_legal(legal[3]));
   end
   // -------------------------------------
   // helpers
   // -------------------------------------
   task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one request through the fabric register, then wait lat edges for its answer
   task automatic op(input int p, input logic w, input logic [12:0] a, input logic [17:0] d, input int lat);
      @(posedge mclk);
      go[p] <= 1'b1;
      we[p] <= w;
      addr[p] <= a;
      data[p] <= d;
      @(posedge mclk);
      go[p] <= 1'b0;
      repeat (lat) @(posedge mclk);
      #1;
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // -------------------------------------
   // scenarios
   // -------------------------------------
   task automatic t_reset;
      chk("legal_ram", 18'h00001, {17'h00000, legal[0]});
      chk("legal_fifo", 18'h00001, {17'h00000, legal[1]});
      chk("fifo_empty", 18'h00001, {17'h00000, empty[1]});
      $display("test reset done");
   endtask
   task automatic t_rom;
      rom[0] <= 1'b1;
      op(0, 1'b1, 13'h0000, 18'h001ff, 2);
      op(0, 1'b0, 13'h0000, 18'h00000, 2);
      chk("rom_word0", {9'h000, INIT[8:0]}, rd[0]);
      op(0, 1'b0, 13'h0001, 18'h00000, 2);
      chk("rom_word1", {9'h000, INIT[17:9]}, rd[0]);
      rom[0] <= 1'b0;
      $display("test rom done");
   endtask
   task automatic t_map;
      op(0, 1'b1, 13'h0002, 18'h001a5, 2);
      op(0, 1'b0, 13'h0002, 18'h00000, 2);
      chk("word_a", 18'h001a5, rd[0]);
      for (int i = 0; i < 9; i++) begin
         op(1, 1'b0, 13'(18 + i), 18'h00000, 3);
         chk("bit_b", {17'h00000, 1'(9'h1a5 >> i)}, rd[1]);
      end
      op(0, 1'b0, 13'h0400, 18'h00000, 2);
      chk("beyond_depth", 18'h00000, rd[0]);
      $display("test map done");
   endtask
   task automatic t_fifo;
      op(2, 1'b1, 13'h0000, 18'h2a5c3, 2);
      chk("empty_push", 18'h00000, {17'h00000, empty[1]});
      op(3, 1'b0, 13'h0000, 18'h00000, 2);
      chk("pop_low", 18'h001c3, rd[3]);
      op(3, 1'b0, 13'h0000, 18'h00000, 2);
      chk("pop_high", 18'h00152, rd[3]);
      chk("empty_pops", 18'h00001, {17'h00000, empty[1]});
      op(3, 1'b0, 13'h0000, 18'h00000, 2);
      chk("pop_dropped", 18'h00152, rd[3]);
      @(posedge mclk);
      go[2] <= 1'b1;
      data[2] <= 18'h3ffff;
      repeat (512) @(posedge mclk);
      go[2] <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk("full", 18'h00001, {17'h00000, full[1]});
      $display("test fifo done");
   endtask
   task automatic t_modes;
      chk("legal_more", 18'h00003, {16'h0000, legal[3:2]});
      chk("ram_flags", 18'h00001, {16'h0000, full[0], empty[0]});
      chk("fifo_a_quiet", 18'h00000, rd[2]);
      op(1, 1'b1, 13'h0001, 18'h00001, 2);
      op(0, 1'b0, 13'h0000, 18'h00000, 2);
      chk("b_write", {9'h000, INIT[8:2], 1'b1, INIT[0]}, rd[0]);
      op(4, 1'b1, 13'h0005, 18'h0000a, 2);
      op(5, 1'b1, 13'h0005, 18'h00005, 2);
      op(4, 1'b0, 13'h0005, 18'h00000, 3);
      chk("single_word", 18'h0000a, rd[4]);
      op(4, 1'b0, 13'h0800, 18'h00000, 3);
      chk("single_beyond", 18'h00000, rd[4]);
      op(6, 1'b1, 13'h0000, 18'h000ab, 2);
      op(6, 1'b1, 13'h0001, 18'h00155, 2);
      op(7, 1'b1, 13'h0000, 18'h3ffff, 2);
      op(7, 1'b0, 13'h0000, 18'h00000, 2);
      chk("pseudo_wide", 18'h2aaab, rd[7]);
      chk("pseudo_a_quiet", 18'h00000, rd[6]);
      $display("test modes done");
   endtask
   // a hang is cut well past the ~650 cycles the run needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1;
      t_reset();
      t_rom();
      t_map();
      t_fifo();
      t_modes();
      finish_test();
   end
endmodule
`default_nettype wire
